// [core/sstx_pkg.sv]
// Purpose: shared constants for the synchronous serial master transmitter
// Assumes: core clock 100 MHz, base bit rate 10 MHz, serial clock = base rate / 4
// Notes:   serial clock idles high, data changes on odd edges, sampled on even edges
package sstx_pkg;

  localparam int unsigned CORE_CLK_HZ    = 100_000_000;
  localparam int unsigned BASE_RATE_HZ   = 10_000_000;
  localparam int unsigned SCLK_DIVIDE    = 4;
  localparam int unsigned BASE_CYCLES    = CORE_CLK_HZ / BASE_RATE_HZ;
  // one serial clock half period, in core cycles (20 at the defaults)
  localparam int unsigned HALF_CYCLES    = (BASE_CYCLES * SCLK_DIVIDE) / 2;
  localparam int unsigned DATA_BITS      = 8;
  localparam int unsigned FRAME_MAX_BITS = DATA_BITS + 1;
  // lead and negation delays: one serial clock each, counted in half periods
  localparam logic [4:0]  LEAD_EDGES     = 5'h02;
  localparam logic [4:0]  TAIL_EDGES     = 5'h02;
  // next access delay: one serial clock plus two core cycles
  localparam int unsigned GAP_EXTRA      = 2;
  localparam logic [7:0]  GAP_CYCLES     = 8'(2 * HALF_CYCLES + GAP_EXTRA);
  localparam logic        SCLK_IDLE      = 1'b1;
  localparam logic        MOSI_IDLE      = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_LEAD,
    ST_SHIFT,
    ST_TAIL,
    ST_GAP
  } link_state_t;

endpackage

// [core/sstx_half_tick.sv]
// Purpose: serial clock half period enable pulse
// Assumes: run_i low resets the count so the first half period is full length
// Notes:   one clock domain; tick_o is a one-cycle enable
`timescale 1ns/100ps
module sstx_half_tick #(
  parameter int unsigned HALF = 20
) (
  input  wire logic core_clk_i,
  input  wire logic nrst_i,
  input  wire logic run_i,
  output logic      tick_o
);

  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       tick_d;
  logic       tick_q;

  always_comb begin
    cnt_d  = 8'h00;
    tick_d = 1'b0;
    if (run_i) begin
      if (cnt_q == 8'(HALF - 1)) begin
        tick_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q  <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      tick_q <= tick_d;
    end
  end

  assign tick_o = tick_q & run_i;

endmodule

// [core/sync_serial_master_tx.sv]
// Purpose: three-wire clock-synchronous serial master transmitter
// Assumes: processor side runs on core_clk_i; no pin is sampled from outside
// Notes:   own line is looped back into the receive path so error flags have data
`timescale 1ns/100ps
// Behaviour
// - three-wire master: serial clock, master-out data and slave select, no receive pin
// - master-out data changes on odd serial clock edges of a frame
// - data is sampled on even serial clock edges
// - serial clock line held high whenever no transfer runs
// - all slave select outputs negated when a transfer completes
// - overrun flag set when previous unread byte is overwritten by a newly received one
// - parity flag set when received parity does not match
// - underrun flag exists, meaningful only as slave, so stays zero here
module sync_serial_master_tx
  import sstx_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       nrst_i,
  input  wire logic       module_enable_i,
  input  wire logic       parity_enable_i,
  input  wire logic       tx_irq_enable_i,
  input  wire logic       rx_irq_enable_i,
  input  wire logic       idle_irq_enable_i,
  input  wire logic       error_irq_enable_i,
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_write_i,
  input  wire logic       rx_read_i,
  input  wire logic       flag_clear_i,
  output logic            serial_clock_line_o,
  output logic            mosi_o,
  output logic            slave_select_line_n_o,
  output logic [7:0]      rx_data_o,
  output logic            overrun_error_flag_o,
  output logic            parity_error_flag_o,
  output logic            underrun_error_flag_o,
  output logic            transmit_empty_interrupt_o,
  output logic            receive_full_interrupt_o,
  output logic            idle_interrupt_o,
  output logic            error_interrupt_o
);

  link_state_t state_q, state_d;
  logic [4:0]  edge_q, edge_d;
  logic [7:0]  gap_q, gap_d;
  logic        sclk_q, sclk_d;
  logic        mosi_q, mosi_d;
  logic        ssel_n_q, ssel_n_d;
  logic [8:0]  tx_shift_q, tx_shift_d;
  logic [8:0]  rx_shift_q, rx_shift_d;
  logic [7:0]  tx_buf_q, tx_buf_d;
  logic        tx_full_q, tx_full_d;
  logic [7:0]  rx_data_q, rx_data_d;
  logic        rx_full_q, rx_full_d;
  logic        par_q, par_d;
  logic        ovr_q, ovr_d;
  logic        per_q, per_d;
  logic        done_q, done_d;
  logic [7:0]  low_run_q, low_run_d;
  logic        tick;
  logic        run;

  function automatic logic [4:0] frame_edges(input logic with_par);
    frame_edges = with_par ? 5'(2 * FRAME_MAX_BITS) : 5'(2 * DATA_BITS);
  endfunction

  assign run = (state_q == ST_LEAD) || (state_q == ST_SHIFT) || (state_q == ST_TAIL);

  sstx_half_tick #(
    .HALF (HALF_CYCLES)
  ) u_half_tick (
    .core_clk_i (core_clk_i),
    .nrst_i     (nrst_i),
    .run_i      (run),
    .tick_o     (tick)
  );

  always_comb begin
    state_d    = state_q;
    edge_d     = edge_q;
    gap_d      = gap_q;
    sclk_d     = sclk_q;
    mosi_d     = mosi_q;
    ssel_n_d   = ssel_n_q;
    tx_shift_d = tx_shift_q;
    rx_shift_d = rx_shift_q;
    tx_buf_d   = tx_buf_q;
    tx_full_d  = tx_full_q;
    rx_data_d  = rx_data_q;
    rx_full_d  = rx_full_q;
    par_d      = par_q;
    ovr_d      = ovr_q;
    per_d      = per_q;
    done_d     = 1'b0;
    // low time of the serial clock, kept for the half period check
    low_run_d  = sclk_q ? 8'h00 : low_run_q + 8'h01;
    // processor side: write refills buffer, read empties receive slot
    if (tx_write_i) begin
      tx_buf_d  = tx_data_i;
      tx_full_d = 1'b1;
    end
    if (rx_read_i) begin
      rx_full_d = 1'b0;
    end
    if (flag_clear_i) begin
      ovr_d = 1'b0;
      per_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        sclk_d   = SCLK_IDLE;
        ssel_n_d = 1'b1;
        if (module_enable_i && tx_full_q) begin
          tx_shift_d = {tx_buf_q, ^tx_buf_q};
          par_d      = parity_enable_i;
          tx_full_d  = tx_write_i;
          ssel_n_d   = 1'b0;
          edge_d     = 5'h00;
          state_d    = ST_LEAD;
        end
      end
      ST_LEAD: begin
        if (tick) begin
          edge_d = edge_q + 5'h01;
          if (edge_q + 5'h01 == LEAD_EDGES) begin
            edge_d  = 5'h00;
            state_d = ST_SHIFT;
          end
        end
      end
      ST_SHIFT: begin
        if (tick) begin
          edge_d = edge_q + 5'h01;
          if (!edge_q[0]) begin
            sclk_d     = 1'b0;
            mosi_d     = tx_shift_q[8];
            tx_shift_d = {tx_shift_q[7:0], 1'b0};
          end else begin
            sclk_d     = 1'b1;
            rx_shift_d = {rx_shift_q[7:0], mosi_q};
            if (edge_q + 5'h01 == frame_edges(par_q)) begin
              done_d  = 1'b1;
              edge_d  = 5'h00;
              state_d = ST_TAIL;
            end
          end
        end
      end
      ST_TAIL: begin
        if (tick) begin
          edge_d = edge_q + 5'h01;
          if (edge_q + 5'h01 == TAIL_EDGES) begin
            ssel_n_d = 1'b1;
            gap_d    = 8'h00;
            state_d  = ST_GAP;
          end
        end
      end
      ST_GAP: begin
        gap_d = gap_q + 8'h01;
        if (gap_q + 8'h01 == GAP_CYCLES) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // receive slot; set of a flag wins over a clear in the same cycle
    if (done_q) begin
      rx_data_d = par_q ? rx_shift_q[8:1] : rx_shift_q[7:0];
      rx_full_d = 1'b1;
      if (rx_full_q && !rx_read_i) begin
        ovr_d = 1'b1;
      end
      if (par_q && (^rx_shift_q)) begin
        per_d = 1'b1;
      end
    end
    // leaving enable aborts at once with clock and select lines back at idle
    if (!module_enable_i) begin
      state_d  = ST_IDLE;
      sclk_d   = SCLK_IDLE;
      ssel_n_d = 1'b1;
      done_d   = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q    <= ST_IDLE;
      edge_q     <= 5'h00;
      gap_q      <= 8'h00;
      sclk_q     <= SCLK_IDLE;
      mosi_q     <= MOSI_IDLE;
      ssel_n_q   <= 1'b1;
      tx_shift_q <= 9'h000;
      rx_shift_q <= 9'h000;
      tx_buf_q   <= 8'h00;
      tx_full_q  <= 1'b0;
      rx_data_q  <= 8'h00;
      rx_full_q  <= 1'b0;
      par_q      <= 1'b0;
      ovr_q      <= 1'b0;
      per_q      <= 1'b0;
      done_q     <= 1'b0;
      low_run_q  <= 8'h00;
    end else begin
      state_q    <= state_d;
      edge_q     <= edge_d;
      gap_q      <= gap_d;
      sclk_q     <= sclk_d;
      mosi_q     <= mosi_d;
      ssel_n_q   <= ssel_n_d;
      tx_shift_q <= tx_shift_d;
      rx_shift_q <= rx_shift_d;
      tx_buf_q   <= tx_buf_d;
      tx_full_q  <= tx_full_d;
      rx_data_q  <= rx_data_d;
      rx_full_q  <= rx_full_d;
      par_q      <= par_d;
      ovr_q      <= ovr_d;
      per_q      <= per_d;
      done_q     <= done_d;
      low_run_q  <= low_run_d;
    end
  end

  // only clock, data and select lines leave the block; receive is the own line looped back
  assign serial_clock_line_o   = sclk_q;
  assign mosi_o                = mosi_q;
  assign slave_select_line_n_o = ssel_n_q;
  assign rx_data_o             = rx_data_q;
  assign overrun_error_flag_o  = ovr_q;
  assign parity_error_flag_o   = per_q;
  // master only: data is never missing when needed, so this reads zero
  assign underrun_error_flag_o = 1'b0;
  // pacing by empty buffer; the processor refills it from this interrupt
  assign transmit_empty_interrupt_o = tx_irq_enable_i & module_enable_i & ~tx_full_q;
  assign receive_full_interrupt_o   = rx_irq_enable_i & rx_full_q;
  assign idle_interrupt_o = idle_irq_enable_i & (state_q == ST_IDLE) & ~tx_full_q;
  assign error_interrupt_o = error_irq_enable_i & (ovr_q | per_q);

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);

  AST_MOSI_QUIET_IDLE: assert property (
    (state_q == ST_IDLE) && $past(state_q == ST_IDLE) |-> $stable(mosi_o))
    else $error("data line moved outside a frame");
  AST_DATA_ON_ODD: assert property (
    !slave_select_line_n_o && $changed(mosi_o) |-> $fell(serial_clock_line_o))
    else $error("data changed off a falling serial clock edge");
  AST_SAMPLE_ON_EVEN: assert property (
    (state_q == ST_SHIFT) && $rose(serial_clock_line_o) |-> rx_shift_q[0] == $past(mosi_o))
    else $error("data not sampled on rising edge");
  AST_CLOCK_IDLE_HIGH: assert property (
    slave_select_line_n_o |-> serial_clock_line_o)
    else $error("serial clock low outside a transfer");
  AST_SELECT_NEGATED: assert property (
    done_q && module_enable_i |-> ##[1:45] slave_select_line_n_o)
    else $error("select not negated after frame");
  AST_OVERRUN_SET: assert property (
    done_q && rx_full_q && !rx_read_i |=> overrun_error_flag_o)
    else $error("lost byte did not set overrun");
  AST_PARITY_SET: assert property (
    done_q && par_q && (^rx_shift_q) |=> parity_error_flag_o)
    else $error("parity mismatch not flagged");
  AST_NO_UNDERRUN: assert property (
    !underrun_error_flag_o)
    else $error("underrun raised in master operation");
  AST_MSB_FIRST: assert property (
    $fell(serial_clock_line_o) |-> mosi_o == $past(tx_shift_q[8]))
    else $error("bit order broken");
  AST_HALF_PERIOD: assert property (
    $rose(serial_clock_line_o) && ((state_q == ST_SHIFT) || (state_q == ST_TAIL))
      |-> low_run_q == 8'(HALF_CYCLES))
    else $error("serial clock low half period wrong length");
  AST_FRAME_EDGES: assert property (
    done_q |-> $past(edge_q) + 5'h01 == frame_edges(par_q))
    else $error("frame length wrong");

  COV_FRAME: cover property ($rose(slave_select_line_n_o));
  COV_PARITY_FRAME: cover property (done_q && par_q);
  COV_OVERRUN: cover property ($rose(overrun_error_flag_o));
  COV_BACK_TO_BACK: cover property (state_q == ST_GAP ##1 state_q == ST_IDLE && tx_full_q);

endmodule

// [bench/serial_receiver_model.sv]
// Purpose: behavioural receiver on the far side of the serial link
// Assumes: clock idles high, so the even edges are the rising ones
// Notes:   done_o pulses 1 ns when select negates after at least one bit
`timescale 1ns/100ps
module serial_receiver_model (
  input  wire logic sclk_i,
  input  wire logic mosi_i,
  input  wire logic select_n_i,
  output logic [8:0] bits_o = 9'h000,
  output logic [3:0] count_o = 4'h0,
  output logic       done_o = 1'b0
);
  always @(negedge select_n_i) begin
    bits_o = 9'h000;
    count_o = 4'h0;
  end
  // captures on even edges; nothing is ever driven back
  always @(posedge sclk_i) begin
    if (!select_n_i) begin
      bits_o = {bits_o[7:0], mosi_i};
      count_o = count_o + 4'h1;
    end
  end
  always @(posedge select_n_i) begin
    if (count_o != 4'h0) begin
      done_o = 1'b1;
      #1 done_o = 1'b0;
    end
  end
endmodule

// [bench/tb.sv]
// Purpose: self-checking bench for the serial master transmitter
// Assumes: frames of 8 bits, 9 with even parity; select active low
// Notes:   driver queues expected frames, watcher checks them at select negation
`timescale 1ns/100ps
module tb;
  import sstx_pkg::*;
  logic core_clk_i, nrst_i, module_enable_i, parity_enable_i;
  logic tx_irq_enable_i, rx_irq_enable_i, idle_irq_enable_i, error_irq_enable_i;
  logic [7:0] tx_data_i, rx_data_o;
  logic tx_write_i, rx_read_i, flag_clear_i, serial_clock_line_o, mosi_o;
  logic slave_select_line_n_o, overrun_error_flag_o, parity_error_flag_o;
  logic underrun_error_flag_o, transmit_empty_interrupt_o, receive_full_interrupt_o;
  logic idle_interrupt_o, error_interrupt_o, done, sclk_p, sel_p, mosi_p;
  logic [8:0] bits;
  logic [3:0] count;
  logic [11:0] q[$];
  logic [11:0] note;
  logic [7:0] b;
  logic [31:0] seed = 32'ha10d;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;
  sync_serial_master_tx i_sync_serial_master_tx (.*);
  serial_receiver_model i_serial_receiver_model (.sclk_i(serial_clock_line_o),
    .mosi_i(mosi_o), .select_n_i(slave_select_line_n_o), .bits_o(bits),
    .count_o(count), .done_o(done));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string name, input logic [8:0] exp, input logic [8:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic tick();
    @(posedge core_clk_i);
    #1;
  endtask
  // nbits 0 marks a frame that is going to be aborted
  task automatic send(input logic [7:0] d, input logic par, input logic [3:0] nbits);
    do tick(); while (transmit_empty_interrupt_o !== 1'b1);
    @(posedge core_clk_i);
    parity_enable_i <= par;
    tx_data_i <= d;
    tx_write_i <= 1'b1;
    q.push_back({nbits, d});
    @(posedge core_clk_i);
    tx_write_i <= 1'b0;
  endtask
  task automatic pulse_read();
    @(posedge core_clk_i);
    rx_read_i <= 1'b1;
    @(posedge core_clk_i);
    rx_read_i <= 1'b0;
    tick();
    chk("rx_full_clr", 0, receive_full_interrupt_o);
  endtask
  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      end_of_test();
    end
  end
  always @(posedge core_clk_i) begin
    #1;
    if (slave_select_line_n_o === 1'b1) chk("sclk_idle", 1, serial_clock_line_o);
    if (!sel_p && !slave_select_line_n_o && mosi_o !== mosi_p)
      chk("mosi_edge", 2, {sclk_p, serial_clock_line_o});
    {sclk_p, sel_p, mosi_p} = {serial_clock_line_o, slave_select_line_n_o, mosi_o};
  end
  always @(posedge done) begin
    note = q.pop_front();
    if (note[11:8] == 4'h0) chk("abort_bits", 1, count < 4'h9);
    else begin
      chk("frame_bits", note[11:8], count);
      chk("frame_data", note[7:0], note[8] ? bits[8:1] : bits[7:0]);
      if (note[8]) chk("parity_bit", ^note[7:0], bits[0]);
    end
  end
  initial begin
    {nrst_i, module_enable_i, parity_enable_i, idle_irq_enable_i} = 4'h0;
    {tx_irq_enable_i, rx_irq_enable_i, error_irq_enable_i} = 3'h7;
    {tx_data_i, tx_write_i, rx_read_i, flag_clear_i} = 11'h000;
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    module_enable_i <= 1'b1;
    tick();
    chk("select_reset", 1, slave_select_line_n_o);
    chk("underrun", 0, underrun_error_flag_o);
    chk("tx_empty_irq", 1, transmit_empty_interrupt_o);
    for (int i = 0; i < 6; i++) begin
      b = 8'(rnd());
      send(b, i[0], i[0] ? 4'h9 : 4'h8);
      do tick(); while (receive_full_interrupt_o !== 1'b1);
      chk("rx_data", b, rx_data_o);
      chk("parity_flag", 0, parity_error_flag_o);
      pulse_read();
    end
    send(8'h81, 1'b0, 4'h8);
    send(8'h7e, 1'b0, 4'h8);
    while (q.size() != 0) tick();
    repeat (3) tick();
    chk("overrun", 1, overrun_error_flag_o);
    chk("error_irq", 1, error_interrupt_o);
    @(posedge core_clk_i);
    flag_clear_i <= 1'b1;
    @(posedge core_clk_i);
    flag_clear_i <= 1'b0;
    tick();
    chk("overrun_clr", 0, overrun_error_flag_o);
    pulse_read();
    @(posedge core_clk_i);
    idle_irq_enable_i <= 1'b1;
    send(8'(rnd()), 1'b0, 4'h0);
    do tick(); while (slave_select_line_n_o !== 1'b0);
    repeat (100) tick();
    chk("idle_busy", 0, idle_interrupt_o);
    @(posedge core_clk_i);
    module_enable_i <= 1'b0;
    repeat (2) tick();
    chk("abort_select", 1, slave_select_line_n_o);
    @(posedge core_clk_i);
    module_enable_i <= 1'b1;
    send(8'h5a, 1'b1, 4'h9);
    while (q.size() != 0) tick();
    repeat (60) tick();
    chk("idle_irq", 1, idle_interrupt_o);
    end_of_test();
  end
endmodule
